// ---- logic/gpm_port.sv ----
// gpio port latches, mode registers and per-pin driver controls
// assumes sfr writes and reads arrive as single-cycle synchronous strobes
`timescale 1ns/1ps
module gpm_port (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic reset_pin_disable_cfg,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_rmw,
	input wire logic [2:0] sfr_port,
	input wire logic [2:0] sfr_sel,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [47:0] pin_in,
	output logic [47:0] drive_low,
	output logic [47:0] pull_strong,
	output logic [47:0] pull_weak,
	output logic [47:0] pull_very_weak,
	output logic [47:0] schmitt_sel,
	output logic [3:0] port1_drive_strength,
	output logic dual_pin_pullup_en
);
	typedef struct packed {
		logic [5:0][7:0] port_data_reg;
		logic [5:0][7:0] port_mode_sel_lo;
		logic [5:0][7:0] port_mode_sel_hi;
		logic [5:0][7:0] port_input_schmitt_sel;
		logic [7:0] drive;
		logic [47:0][1:0] strong_cnt;
		logic [7:0] rdata;
	} gpm_state_s;

	gpm_state_s st;
	gpm_state_s next_st;

	function automatic logic [7:0] gpm_used(input logic [2:0] p);
		gpm_used = (p < 3'(gpm_pkg::NPORT)) ? gpm_pkg::PORT_USED[p] : 8'h00;
	endfunction : gpm_used

	logic [7:0] pin_view;
	always_comb begin
		pin_view = 8'h00;
		if (sfr_port < 3'(gpm_pkg::NPORT))
			pin_view = pin_in[sfr_port*8 +: 8] & gpm_used(sfr_port);
		// dual pin reads 0 while it serves as reset
		// read as zero
		if (sfr_port == gpm_pkg::DUAL_PORT && !reset_pin_disable_cfg)
			pin_view[gpm_pkg::DUAL_BIT] = 1'b0;
	end

	always_comb begin
		logic [7:0] m;
		m = 8'h00;
		next_st = st;
		m = gpm_used(sfr_port);
		for (int i = 0; i < 48; i++) begin
			if (st.strong_cnt[i] != 2'h0)
				next_st.strong_cnt[i] = st.strong_cnt[i] - 2'h1;
		end
		if (sfr_wr && sfr_port < 3'(gpm_pkg::NPORT)) begin
			case (sfr_sel)
			gpm_pkg::SEL_DATA: begin
				next_st.port_data_reg[sfr_port] = sfr_wdata | ~m;
				for (int b = 0; b < 8; b++) begin
					if (!st.port_data_reg[sfr_port][b] && sfr_wdata[b] &&
						!st.port_mode_sel_lo[sfr_port][b] &&
						!st.port_mode_sel_hi[sfr_port][b])
						next_st.strong_cnt[sfr_port*8+b] = gpm_pkg::STRONG_LOAD;
				end
			end
			gpm_pkg::SEL_MODE_LO:
				next_st.port_mode_sel_lo[sfr_port] = sfr_wdata & m;
			gpm_pkg::SEL_MODE_HI:
				next_st.port_mode_sel_hi[sfr_port] = sfr_wdata & m;
			gpm_pkg::SEL_SCHMITT:
				next_st.port_input_schmitt_sel[sfr_port] = sfr_wdata & m;
			gpm_pkg::SEL_DRIVE:
				if (sfr_port == gpm_pkg::DRV_PORT)
					next_st.drive = sfr_wdata & gpm_pkg::DRV_MASK;
			default: ;
			endcase
		end
		if (sfr_rd) begin
			case (sfr_sel)
			gpm_pkg::SEL_DATA:
				next_st.rdata = sfr_rmw ?
					(st.port_data_reg[sfr_port] & m) : pin_view;
			gpm_pkg::SEL_MODE_LO: next_st.rdata = st.port_mode_sel_lo[sfr_port];
			gpm_pkg::SEL_MODE_HI: next_st.rdata = st.port_mode_sel_hi[sfr_port];
			gpm_pkg::SEL_SCHMITT:
				next_st.rdata = st.port_input_schmitt_sel[sfr_port];
			gpm_pkg::SEL_DRIVE:
				next_st.rdata = (sfr_port == gpm_pkg::DRV_PORT) ? st.drive : 8'h00;
			default: next_st.rdata = 8'h00;
			endcase
			if (sfr_port >= 3'(gpm_pkg::NPORT))
				next_st.rdata = 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st.port_data_reg <= {6{gpm_pkg::RST_DATA}};
			st.port_mode_sel_lo <= {6{gpm_pkg::RST_MODE_LO}};
			st.port_mode_sel_hi <= {6{gpm_pkg::RST_MODE_HI}};
			st.port_input_schmitt_sel <= {6{gpm_pkg::RST_SCHMITT}};
			st.drive <= gpm_pkg::RST_DRIVE;
			st.strong_cnt <= '0;
			st.rdata <= 8'h00;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign sfr_rdata = st.rdata;
	assign port1_drive_strength = st.drive[3:0];

	always_comb begin
		logic lo;
		logic hi;
		logic lat;
		lo = 1'b0;
		hi = 1'b0;
		lat = 1'b0;
		for (int i = 0; i < 48; i++) begin
			lo = st.port_mode_sel_lo[i/8][i%8];
			hi = st.port_mode_sel_hi[i/8][i%8];
			lat = st.port_data_reg[i/8][i%8];
			drive_low[i] = 1'b0;
			pull_strong[i] = 1'b0;
			pull_weak[i] = 1'b0;
			pull_very_weak[i] = 1'b0;
			schmitt_sel[i] = st.port_input_schmitt_sel[i/8][i%8];
			case ({lo, hi})
			2'b00: begin
				drive_low[i] = !lat;
				pull_very_weak[i] = lat;
				pull_weak[i] = lat && pin_in[i];
				pull_strong[i] = lat && st.strong_cnt[i] != 2'h0;
			end
			2'b01: begin
				drive_low[i] = !lat;
				pull_strong[i] = lat;
			end
			2'b11: drive_low[i] = !lat;
			default: ;
			endcase
			if (!gpm_pkg::PORT_USED[i/8][i%8]) begin
				drive_low[i] = 1'b0;
				pull_strong[i] = 1'b0;
				pull_weak[i] = 1'b0;
				pull_very_weak[i] = 1'b0;
				schmitt_sel[i] = 1'b0;
			end
		end
		drive_low[gpm_pkg::DUAL_PORT*8+gpm_pkg::DUAL_BIT] = 1'b0;
		pull_strong[gpm_pkg::DUAL_PORT*8+gpm_pkg::DUAL_BIT] = 1'b0;
		pull_weak[gpm_pkg::DUAL_PORT*8+gpm_pkg::DUAL_BIT] = 1'b0;
		pull_very_weak[gpm_pkg::DUAL_PORT*8+gpm_pkg::DUAL_BIT] = 1'b0;
		schmitt_sel[gpm_pkg::DUAL_PORT*8+gpm_pkg::DUAL_BIT] = 1'b1;
	end

	assign dual_pin_pullup_en = !reset_pin_disable_cfg ||
		st.port_mode_sel_hi[gpm_pkg::DUAL_PORT][gpm_pkg::DUAL_BIT];

	property p_strong_len;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && st.strong_cnt[0] == 2'h0 &&
		next_st.strong_cnt[0] == gpm_pkg::STRONG_LOAD) |=>
		st.strong_cnt[0] == gpm_pkg::STRONG_LOAD ##1
		(!$past(clk_en) || st.strong_cnt[0] == 2'h1);
	endproperty
	a_strong_len: assert property (p_strong_len)
		else $error("strong pullup count wrong");

	property p_pp_high;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.port_mode_sel_lo[0][0] && st.port_mode_sel_hi[0][0] &&
		st.port_data_reg[0][0]) |-> pull_strong[0] && !drive_low[0];
	endproperty
	a_pp_high: assert property (p_pp_high)
		else $error("push-pull high wrong");

	property p_in_only;
		@(posedge clk_sys) disable iff (!rst_n)
		(st.port_mode_sel_lo[1][2] && !st.port_mode_sel_hi[1][2]) |->
		!(drive_low[10] || pull_strong[10] || pull_weak[10] ||
		pull_very_weak[10]);
	endproperty
	a_in_only: assert property (p_in_only)
		else $error("input-only pin driven");

	property p_od;
		@(posedge clk_sys) disable iff (!rst_n)
		(st.port_mode_sel_lo[0][1] && st.port_mode_sel_hi[0][1]) |->
		!pull_strong[1] && !pull_weak[1] && drive_low[1] ==
		!st.port_data_reg[0][1];
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain drive wrong");

	property p_quasi_low;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.port_mode_sel_lo[2][0] && !st.port_mode_sel_hi[2][0] &&
		!st.port_data_reg[2][0]) |-> drive_low[16] && !pull_very_weak[16];
	endproperty
	a_quasi_low: assert property (p_quasi_low)
		else $error("quasi low wrong");

	property p_weak;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.port_mode_sel_lo[0][3] && !st.port_mode_sel_hi[0][3]) |->
		pull_weak[3] == (st.port_data_reg[0][3] && pin_in[3]) &&
		pull_very_weak[3] == st.port_data_reg[0][3];
	endproperty
	a_weak: assert property (p_weak)
		else $error("weak pullup wrong");

	property p_dual_read;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && sfr_rd && !sfr_rmw && sfr_sel == gpm_pkg::SEL_DATA &&
		sfr_port == gpm_pkg::DUAL_PORT && !reset_pin_disable_cfg) |=>
		!sfr_rdata[gpm_pkg::DUAL_BIT];
	endproperty
	a_dual_read: assert property (p_dual_read)
		else $error("dual pin not read as zero");

	property p_cfg_wr;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_sel == gpm_pkg::SEL_MODE_HI &&
		sfr_port == 3'h0) |=> st.port_mode_sel_hi[0] == $past(sfr_wdata);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr)
		else $error("mode write not taken");

	property p_rmw;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && sfr_rd && sfr_rmw && sfr_sel == gpm_pkg::SEL_DATA &&
		sfr_port == 3'h1) |=> sfr_rdata == $past(st.port_data_reg[1]);
	endproperty
	a_rmw: assert property (p_rmw)
		else $error("rmw read not from latch");

	property p_very_weak;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.port_mode_sel_lo[4][1] && !st.port_mode_sel_hi[4][1]) |->
		pull_very_weak[33] == st.port_data_reg[4][1];
	endproperty
	a_very_weak: assert property (p_very_weak)
		else $error("very weak pullup wrong");

	property p_drive_wr;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_sel == gpm_pkg::SEL_DRIVE &&
		sfr_port == gpm_pkg::DRV_PORT) |=>
		{4'h0, port1_drive_strength} ==
		($past(sfr_wdata) & gpm_pkg::DRV_MASK);
	endproperty
	a_drive_wr: assert property (p_drive_wr)
		else $error("drive strength write not taken");

	property p_schmitt_wr;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_sel == gpm_pkg::SEL_SCHMITT &&
		sfr_port == 3'h1) |=> schmitt_sel[15:8] == $past(sfr_wdata);
	endproperty
	a_schmitt_wr: assert property (p_schmitt_wr)
		else $error("input type select not taken");

	property p_dual_in;
		@(posedge clk_sys) disable iff (!rst_n)
		!drive_low[30] && !pull_strong[30] && !pull_weak[30] &&
		!pull_very_weak[30] && schmitt_sel[30];
	endproperty
	a_dual_in: assert property (p_dual_in)
		else $error("dual pin not a plain schmitt input");

	property p_dual_pu;
		@(posedge clk_sys) disable iff (!rst_n)
		reset_pin_disable_cfg |->
		dual_pin_pullup_en == st.port_mode_sel_hi[3][6];
	endproperty
	a_dual_pu: assert property (p_dual_pu)
		else $error("dual pin pullup not from mode bit");

	property p_reset_pu;
		@(posedge clk_sys) disable iff (!rst_n)
		!reset_pin_disable_cfg |-> dual_pin_pullup_en;
	endproperty
	a_reset_pu: assert property (p_reset_pu)
		else $error("reset pin pullup off");

	property p_rst_mode;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> drive_low == 48'h0 && pull_strong == 48'h0 &&
		pull_weak == 48'h0 && pull_very_weak == 48'h0;
	endproperty
	a_rst_mode: assert property (p_rst_mode)
		else $error("pin driven after reset");

	property p_rst_data;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> st.port_data_reg == {6{gpm_pkg::RST_DATA}};
	endproperty
	a_rst_data: assert property (p_rst_data)
		else $error("data latch not all ones after reset");
endmodule : gpm_port

// ---- logic/gpm_pkg.sv ----
// constants for the gpio port mode logic: ports, modes, reset values
// assumes an sfr bus that presents a port index and a register select
package gpm_pkg;
	localparam int NPORT = 6;
	localparam int NPIN = 26;
	localparam logic [7:0] PORT_USED [NPORT] = '{8'hff, 8'hff, 8'h0f,
		8'h7f, 8'h0f, 8'h03};
	localparam logic [2:0] DUAL_PORT = 3'h3;
	localparam int DUAL_BIT = 6;
	localparam logic [2:0] DRV_PORT = 3'h1;
	localparam logic [7:0] DRV_MASK = 8'h0f;
	localparam logic [2:0] SEL_DATA = 3'h0;
	localparam logic [2:0] SEL_MODE_LO = 3'h1;
	localparam logic [2:0] SEL_MODE_HI = 3'h2;
	localparam logic [2:0] SEL_SCHMITT = 3'h3;
	localparam logic [2:0] SEL_DRIVE = 3'h4;
	localparam logic [7:0] RST_DATA = 8'hff;
	localparam logic [7:0] RST_MODE_LO = 8'hff;
	localparam logic [7:0] RST_MODE_HI = 8'h00;
	localparam logic [7:0] RST_SCHMITT = 8'h00;
	localparam logic [7:0] RST_DRIVE = 8'h00;
	localparam int STRONG_CYC = 2;
	localparam logic [1:0] STRONG_LOAD = 2'(STRONG_CYC);
endpackage : gpm_pkg

// ---- verif/gpm_pins.sv ----
// board side of the port pins: optional external drivers plus pulls
// assumes the pin controls of gpm_port; weak pull left out to avoid a loop
`timescale 1ns/1ps
module gpm_pins (
	input wire logic clk_sys,
	input wire logic [47:0] drive_low,
	input wire logic [47:0] pull_strong,
	input wire logic [47:0] pull_very_weak,
	input wire logic [47:0] ext_en,
	input wire logic [47:0] ext_val,
	output logic [47:0] pin_in
);
	logic [47:0] last = '0;
	always_ff @(posedge clk_sys) begin
		last <= pin_in;
	end
	// floating pin toggles so a stale level never reads as valid
	always_comb begin
		pin_in = (ext_en & ext_val) | (~ext_en & ~drive_low &
			(pull_strong | pull_very_weak | ~last));
	end
endmodule : gpm_pins

// ---- verif/tb_gpm_port.sv ----
// bench for gpm_port: random port setups against an integer model
// assumes gpm_pins on the pin side, clk_en dropped once to check the freeze
`timescale 1ns/1ps
module tb_gpm_port;
	logic clk_sys = 0, rst_n = 0, cfg = 0, wr = 0, rd = 0, rmw = 0;
	logic en = 1;
	logic [2:0] prt = 0, sel = 0;
	logic [7:0] wd = 0, rdata;
	logic [47:0] pin, dl, ps, pw, pvw, sc, ee = 0, ev = 0;
	logic [3:0] ds;
	logic pu;
	logic [7:0] m [6][5];
	int fail_count = 0, tests_run = 0, cyc = 0;
	always #5 clk_sys = ~clk_sys;
	gpm_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(en),
		.reset_pin_disable_cfg(cfg), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_rmw(rmw), .sfr_port(prt), .sfr_sel(sel), .sfr_wdata(wd),
		.sfr_rdata(rdata), .pin_in(pin), .drive_low(dl),
		.pull_strong(ps), .pull_weak(pw), .pull_very_weak(pvw),
		.schmitt_sel(sc), .port1_drive_strength(ds),
		.dual_pin_pullup_en(pu));
	gpm_pins pins_u (.clk_sys(clk_sys), .drive_low(dl), .pull_strong(ps),
		.pull_very_weak(pvw), .ext_en(ee), .ext_val(ev), .pin_in(pin));
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_rd
	// reset values are whole bytes; unused bits only masked on write
	task automatic model_reset();
		for (int p = 0; p < 6; p++) begin
			m[p] = '{gpm_pkg::RST_DATA, gpm_pkg::RST_MODE_LO,
				gpm_pkg::RST_MODE_HI, gpm_pkg::RST_SCHMITT,
				gpm_pkg::RST_DRIVE};
		end
	endtask : model_reset
	task automatic wr_reg(input int p, input int s, input logic [7:0] d);
		@(negedge clk_sys);
		prt = 3'(p);
		sel = 3'(s);
		wd = d;
		wr = 1;
		@(negedge clk_sys);
		wr = 0;
		if (p < 6 && (s != 4 || p == 1))
			m[p][s] = d & (s == 4 ? gpm_pkg::DRV_MASK : gpm_pkg::PORT_USED[p]);
	endtask : wr_reg
	task automatic rd_reg(input int p, input int s, input logic r);
		logic [7:0] e, k;
		k = (p == 3 && s != 2 && r) ? 8'hbf : 8'hff;
		e = (p > 5 || (s == 4 && p != 1)) ? 8'h00 : (r ? m[p][s] & k &
			(s == 0 ? gpm_pkg::PORT_USED[p] : 8'hff) :
			ev[p*8+:8] & gpm_pkg::PORT_USED[p] & (p == 3 && !cfg ? 8'hbf : 8'hff));
		@(negedge clk_sys);
		prt = 3'(p);
		sel = 3'(s);
		rmw = r;
		rd = 1;
		@(negedge clk_sys);
		rd = 0;
		chk_rd(rdata & k, e);
	endtask : rd_reg
	task automatic chk_pins();
		logic [47:0] el, es, eq, qm, esc;
		for (int b = 0; b < 48; b++) begin
			logic l, lo, hi, u;
			l = m[b/8][0][b%8];
			lo = m[b/8][1][b%8];
			hi = m[b/8][2][b%8];
			u = gpm_pkg::PORT_USED[b/8][b%8] && b != 30;
			el[b] = u & !l & !(lo & !hi);
			es[b] = u & l & !lo & hi;
			qm[b] = u & !lo & !hi;
			eq[b] = qm[b] & l;
			esc[b] = (u & m[b/8][3][b%8]) | (b == 30);
		end
		chk(dl, el);
		chk(ps, es);
		chk(pvw, eq);
		chk(pw & eq, pin & eq);
		chk(pw & ~qm, 48'h0);
		chk(sc, esc);
		chk(48'(pu), 48'(cfg ? m[3][2][6] : 1'b1));
		chk(48'(ds), 48'(m[1][4][3:0]));
	endtask : chk_pins
	initial begin
		void'($urandom(32'h0e2a8244));
		model_reset();
		repeat (16) @(negedge clk_sys);
		rst_n = 1;
		chk_pins();
		for (int p = 0; p < 6; p++) begin
			for (int s = 0; s < 5; s++) begin
				rd_reg(p, s, 1);
			end
		end
		wr_reg(0, 1, 8'h00);
		wr_reg(0, 0, 8'h00);
		wr_reg(0, 0, 8'hff);
		for (int i = 0; i < 3; i++) begin
			chk(48'(ps[7:0]), i < 2 ? 48'hff : 48'h0);
			@(negedge clk_sys);
		end
		chk_pins();
		// write with clock enable low must leave all state frozen
		en = 0;
		wr_reg(4, 3, 8'h0f);
		m[4][3] = gpm_pkg::RST_SCHMITT;
		en = 1;
		chk_pins();
		ee = '1;
		repeat (6) begin
			cfg = 1'($urandom);
			ev = {16'($urandom), $urandom};
			for (int p = 0; p < 6; p++) begin
				for (int s = 0; s < 4; s++) begin
					wr_reg(p, s, 8'($urandom));
				end
			end
			wr_reg(1, 4, 8'($urandom));
			wr_reg(2, 4, 8'hff);
			wr_reg(6, 0, 8'h00);
			repeat (3) @(negedge clk_sys);
			chk_pins();
			for (int p = 0; p < 8; p++) begin
				rd_reg(p, 0, 0);
				for (int s = 0; s < 5; s++) begin
					rd_reg(p, s, 1);
				end
			end
		end
		rst_n = 0;
		model_reset();
		@(negedge clk_sys);
		rst_n = 1;
		chk_pins();
		final_report();
	end
endmodule : tb_gpm_port
